// [sora_pkg.sv]
// Purpose: Constants and types for the secure OTP region access block
// Assumes: Byte addressing on the command port, 256-KB sectors
// Notes: Random seed value is arbitrary
package sora_pkg;
  localparam int unsigned ADDR_W = 26;
  localparam int unsigned OFF_W = 10;
  localparam int unsigned SPACE_BYTES = 1024;
  localparam int unsigned RAND_BYTES = 16;
  localparam int unsigned SECT_LSB = 18;
  localparam int unsigned SECT_W = 8;
  localparam int unsigned WIN_LSB = 13;
  localparam int unsigned REG_W = 16;
  localparam logic [OFF_W-1:0] LOCK_BASE = 10'h010;
  localparam logic [OFF_W-1:0] RAND_END = 10'h010;
  localparam logic [7:0] ERASED = 8'hFF;
  // Factory random number, arbitrary value
  localparam logic [127:0] RAND_SEED = 128'h0F1E2D3C4B5A69788796A5B4C3D2E1F0;
  // Command opcodes
  localparam logic [2:0] OP_ENTER = 3'h1;
  localparam logic [2:0] OP_EXIT = 3'h2;
  localparam logic [2:0] OP_READ = 3'h3;
  localparam logic [2:0] OP_PROG = 3'h4;
  localparam logic [2:0] OP_ERASE = 3'h5;
  // Register offsets
  localparam logic [3:0] REG_CFG = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h4;
  localparam logic [3:0] REG_MASK = 4'h8;
  localparam logic [3:0] REG_OVL = 4'hC;
  // Field positions and reset values
  localparam int unsigned CFG_FREEZE_BIT = 10;
  localparam logic [REG_W-1:0] CFG_RST = 16'h0400;
  localparam logic [REG_W-1:0] CFG_WMASK = 16'h0400;
  localparam int unsigned STAT_DONE_BIT = 0;
  localparam int unsigned STAT_PERR_BIT = 4;
  localparam logic [REG_W-1:0] STAT_WMASK = 16'h0011;
  localparam logic [REG_W-1:0] ZERO16 = 16'h0000;
  typedef enum logic {ST_ARRAY, ST_OVERLAY} sora_state_t;
endpackage : sora_pkg

// [sora_top.sv]
// Purpose: Secure OTP region overlay, program gating, locks and freeze
// Assumes: Host commands arrive decoded, one per cycle, synchronous
// Notes: Reset reloads the delivery image of the secure space
//
// Notes on behaviour
// R1 - The secure space is 1024 bytes in 32 lockable 32-byte regions.
// R2 - Programming zeros into the 16 random bytes fails and sets status 4.
// R3 - The four bytes after the random number hold one lock bit per region.
// R4 - Bit 0 of byte 10h locks region 0 up to bit 7 of 13h for region 31.
// R5 - The twelve reserved bytes 14h to 1Fh accept host programming.
// R6 - Lock, reserved and region 1 to 31 bytes are delivered as FFh.
// R7 - Region n occupies offsets n*32 through n*32+31.
// R8 - A zero freeze bit blocks all programming of the secure space.
// R9 - A program blocked by the freeze bit fails with no error shown.
// R10 - The host enters the overlay, naming its sector, before access.
// R11 - Other sectors read array data; the rest of the window is undefined.
// R12 - The exit command returns the device to normal array read.
// R13 - Programs repeat like array programs and nothing erases the space.
// R14 - Program addresses ignore bit 9 and above of the word address.
// R15 - Sector protection has no effect on secure-space programming.
// R16 - A program into a locked region changes nothing and fails.
module sora_top (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic cmd_valid,
  input wire logic [2:0] cmd_op,
  input wire logic [sora_pkg::ADDR_W-1:0] cmd_addr,
  input wire logic [7:0] cmd_wdata,
  output logic rsp_valid_ff,
  output logic rsp_array_ff,
  output logic rsp_fail_ff,
  output logic [7:0] rsp_rdata_ff,
  output logic overlay_active_ff,
  input wire logic [3:0] reg_addr,
  input wire logic [sora_pkg::REG_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [sora_pkg::REG_W-1:0] reg_rdata_ff,
  output logic irq_ff
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  sora_pkg::sora_state_t state_ff;
  sora_pkg::sora_state_t nxt_state;
  logic [7:0] mem_q [0:sora_pkg::SPACE_BYTES-1];
  logic [sora_pkg::SECT_W-1:0] ovl_sect_ff;
  logic [sora_pkg::REG_W-1:0] cfg_ff;
  logic [sora_pkg::REG_W-1:0] stat_ff;
  logic [sora_pkg::REG_W-1:0] mask_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Command decode

  wire is_enter = cmd_valid && (cmd_op == sora_pkg::OP_ENTER);
  wire is_exit = cmd_valid && (cmd_op == sora_pkg::OP_EXIT);
  wire is_read = cmd_valid && (cmd_op == sora_pkg::OP_READ);
  wire is_prog = cmd_valid && (cmd_op == sora_pkg::OP_PROG);
  wire is_erase = cmd_valid && (cmd_op == sora_pkg::OP_ERASE);
  wire is_access = is_read || is_prog || is_erase;
  wire [sora_pkg::SECT_W-1:0] sect =
    cmd_addr[sora_pkg::SECT_LSB +: sora_pkg::SECT_W];
  wire in_sect = (state_ff == sora_pkg::ST_OVERLAY) && (sect == ovl_sect_ff);
  wire in_win = (cmd_addr[sora_pkg::SECT_LSB-1:sora_pkg::WIN_LSB] == 5'h00);
  // Higher address bits dropped so every offset aliases into the space
  wire [sora_pkg::OFF_W-1:0] off = cmd_addr[sora_pkg::OFF_W-1:0]; // R14 R1
  wire [4:0] region = off[9:5]; // R7
  wire [sora_pkg::OFF_W-1:0] lock_idx =
    sora_pkg::LOCK_BASE + {8'h00, region[4:3]}; // R3
  wire [7:0] lock_byte = mem_q[lock_idx];
  wire region_locked = !lock_byte[region[2:0]]; // R4
  wire frozen = !cfg_ff[sora_pkg::CFG_FREEZE_BIT]; // R8
  wire [7:0] old_byte = mem_q[off];
  wire [7:0] new_byte = old_byte & cmd_wdata; // R13
  // Any bit cleared in the random number is refused
  wire rand_zero = (off < sora_pkg::RAND_END) && (new_byte != old_byte); // R2
  // Only locks, freeze and the random-byte check gate; sector protection is not consulted
  wire prog_fail = !frozen && (region_locked || rand_zero); // R15 R16
  wire prog_hit = is_prog && in_sect;
  wire prog_ok = prog_hit && !frozen && !region_locked && !rand_zero; // R5
  wire perr_evt = prog_hit && prog_fail; // R9
  wire done_evt = prog_hit;

  ////////////////////////////////////////////////////////////////////////////
  // Overlay state machine

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      sora_pkg::ST_ARRAY:
      begin
        if (is_enter)
          nxt_state = sora_pkg::ST_OVERLAY; // R10
      end
      sora_pkg::ST_OVERLAY:
      begin
        if (is_exit)
          nxt_state = sora_pkg::ST_ARRAY; // R12
      end
      default:
        nxt_state = sora_pkg::ST_ARRAY;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      state_ff <= sora_pkg::ST_ARRAY;
      ovl_sect_ff <= 8'h00;
      overlay_active_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      overlay_active_ff <= (nxt_state == sora_pkg::ST_OVERLAY);
      if (is_enter)
        ovl_sect_ff <= sect; // R10
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Secure space storage, bits only ever cleared

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < sora_pkg::SPACE_BYTES; i++)
        mem_q[i] <= (i < sora_pkg::RAND_BYTES) ?
          sora_pkg::RAND_SEED[i*8 +: 8] : sora_pkg::ERASED; // R6
    end
    else if (prog_ok)
      mem_q[off] <= new_byte; // R13
  end

  ////////////////////////////////////////////////////////////////////////////
  // Responses

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      rsp_valid_ff <= 1'b0;
      rsp_array_ff <= 1'b0;
      rsp_fail_ff <= 1'b0;
      rsp_rdata_ff <= 8'h00;
    end
    else
    begin
      rsp_valid_ff <= is_access;
      rsp_array_ff <= is_access && !in_sect; // R11
      // Erase inside the overlay never touches the space
      rsp_fail_ff <= perr_evt || (is_erase && in_sect); // R16 R13
      rsp_rdata_ff <= (is_read && in_sect && in_win) ? old_byte : 8'h00; // R11
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file and interrupt

  wire wr_cfg = reg_wr && (reg_addr == sora_pkg::REG_CFG);
  wire wr_stat = reg_wr && (reg_addr == sora_pkg::REG_STAT);
  wire wr_mask = reg_wr && (reg_addr == sora_pkg::REG_MASK);
  wire [sora_pkg::REG_W-1:0] evt_vec =
    ({15'h0000, perr_evt} << sora_pkg::STAT_PERR_BIT) |
    ({15'h0000, done_evt} << sora_pkg::STAT_DONE_BIT); // R2
  wire [sora_pkg::REG_W-1:0] clr_vec =
    wr_stat ? (reg_wdata & sora_pkg::STAT_WMASK) : sora_pkg::ZERO16;
  wire [sora_pkg::REG_W-1:0] nxt_stat = (stat_ff & ~clr_vec) | evt_vec;
  // Mask change reaches the interrupt on the same edge as the mask itself
  wire [sora_pkg::REG_W-1:0] nxt_mask =
    wr_mask ? (reg_wdata & sora_pkg::STAT_WMASK) : mask_ff;
  wire [sora_pkg::REG_W-1:0] ovl_view =
    {7'h00, overlay_active_ff, ovl_sect_ff};
  wire [sora_pkg::REG_W-1:0] rd_mux =
    (reg_addr == sora_pkg::REG_CFG) ? cfg_ff :
    (reg_addr == sora_pkg::REG_STAT) ? stat_ff :
    (reg_addr == sora_pkg::REG_MASK) ? mask_ff :
    (reg_addr == sora_pkg::REG_OVL) ? ovl_view : sora_pkg::ZERO16;

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      cfg_ff <= sora_pkg::CFG_RST;
      stat_ff <= sora_pkg::ZERO16;
      mask_ff <= sora_pkg::ZERO16;
      reg_rdata_ff <= sora_pkg::ZERO16;
      irq_ff <= 1'b0;
    end
    else
    begin
      if (wr_cfg)
        cfg_ff <= reg_wdata & sora_pkg::CFG_WMASK; // R8
      mask_ff <= nxt_mask;
      stat_ff <= nxt_stat;
      reg_rdata_ff <= reg_rd ? rd_mux : sora_pkg::ZERO16;
      irq_ff <= |(nxt_stat & nxt_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  property p_freeze_silent; // R9
    @(posedge clock) disable iff (!rst_n)
    (is_prog && in_sect && frozen) |=>
      !rsp_fail_ff && (!stat_ff[sora_pkg::STAT_PERR_BIT] ||
      $past(stat_ff[sora_pkg::STAT_PERR_BIT]));
  endproperty
  a_freeze_silent: assert property (p_freeze_silent) // R9
    else $error("frozen program raised an error");

  property p_rand_fail; // R2
    @(posedge clock) disable iff (!rst_n)
    (prog_hit && !frozen && rand_zero) |=>
      rsp_fail_ff && stat_ff[sora_pkg::STAT_PERR_BIT];
  endproperty
  a_rand_fail: assert property (p_rand_fail) // R2
    else $error("zero into random bytes did not fail");

  property p_lock_hold; // R16
    @(posedge clock) disable iff (!rst_n)
    (prog_hit && !frozen && region_locked) |=>
      rsp_fail_ff && (mem_q[$past(off)] == $past(old_byte));
  endproperty
  a_lock_hold: assert property (p_lock_hold) // R16
    else $error("locked region was changed or not failed");

  property p_prog_and; // R13
    @(posedge clock) disable iff (!rst_n)
    prog_ok |=> (mem_q[$past(off)] == $past(new_byte)) && !rsp_fail_ff;
  endproperty
  a_prog_and: assert property (p_prog_and) // R13
    else $error("program result is not old and data");

  property p_enter; // R10
    @(posedge clock) disable iff (!rst_n)
    (is_enter && state_ff == sora_pkg::ST_ARRAY) |=>
      overlay_active_ff && (ovl_sect_ff == $past(sect));
  endproperty
  a_enter: assert property (p_enter) // R10
    else $error("overlay entry not taken");

  property p_exit; // R12
    @(posedge clock) disable iff (!rst_n)
    is_exit |=> !overlay_active_ff && (state_ff == sora_pkg::ST_ARRAY);
  endproperty
  a_exit: assert property (p_exit) // R12
    else $error("overlay exit not taken");

  property p_array_read; // R11
    @(posedge clock) disable iff (!rst_n)
    (is_read && !in_sect) |=> rsp_valid_ff && rsp_array_ff &&
      (rsp_rdata_ff == 8'h00);
  endproperty
  a_array_read: assert property (p_array_read) // R11
    else $error("foreign read not passed to array");

  property p_irq; // R2
    @(posedge clock) disable iff (!rst_n)
    (perr_evt && mask_ff[sora_pkg::STAT_PERR_BIT] && !wr_mask) |=>
      irq_ff [*2] or ($past(wr_stat) || wr_stat || wr_mask);
  endproperty
  a_irq: assert property (p_irq) // R2
    else $error("error did not raise interrupt");

  property p_irq_level; // R2
    @(posedge clock) disable iff (!rst_n)
    1'b1 |-> (irq_ff == (|(stat_ff & mask_ff)));
  endproperty
  a_irq_level: assert property (p_irq_level) // R2
    else $error("interrupt does not follow masked status");

  property p_freeze_keep; // R8
    @(posedge clock) disable iff (!rst_n)
    (prog_hit && frozen) |=>
      rsp_valid_ff && (mem_q[$past(off)] == $past(old_byte));
  endproperty
  a_freeze_keep: assert property (p_freeze_keep) // R8
    else $error("frozen program changed the space");

  property p_window; // R11
    @(posedge clock) disable iff (!rst_n)
    (is_read && in_sect && !in_win) |=>
      rsp_valid_ff && !rsp_array_ff && (rsp_rdata_ff == 8'h00);
  endproperty
  a_window: assert property (p_window) // R11
    else $error("read outside window returned data");

  property p_erase; // R13
    @(posedge clock) disable iff (!rst_n)
    (is_erase && in_sect) |=> rsp_fail_ff && !rsp_array_ff &&
      (mem_q[$past(off)] == $past(old_byte));
  endproperty
  a_erase: assert property (p_erase) // R13
    else $error("erase acted on the secure space");

  property p_done; // R13
    @(posedge clock) disable iff (!rst_n)
    prog_hit |=> rsp_valid_ff && stat_ff[sora_pkg::STAT_DONE_BIT];
  endproperty
  a_done: assert property (p_done) // R13
    else $error("program did not complete");

endmodule : sora_top

// [sora_host.sv]
// Purpose: Host command driver facing the secure OTP region block
// Assumes: One command per call, released after the taking edge
// Notes: Released address and data lines show the inverse of their last value; the opcode holds
module sora_host (
  input wire logic clock,
  output logic cmd_valid,
  output logic [2:0] cmd_op,
  output logic [sora_pkg::ADDR_W-1:0] cmd_addr,
  output logic [7:0] cmd_wdata,
  input wire logic [3:0] rsp
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    cmd_valid = 1'b0;
    cmd_op = 3'h0;
    cmd_addr = 26'h0;
    cmd_wdata = 8'h0;
  end
  ////////////////////////////////////////////////////////////////////////
  // Overlay is entered before any secure access in the bench sequence
  task automatic cmd(input logic [2:0] op, input logic [25:0] a,
    input logic [7:0] d, output logic [3:0] r);
    @(posedge clock);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_addr <= a;
    cmd_wdata <= d;
    @(posedge clock);
    cmd_valid <= 1'b0;
    cmd_addr <= ~a;
    cmd_wdata <= ~d;
    #1 r = rsp;
  endtask : cmd
endmodule : sora_host

// [sora_top_tb.sv]
// Purpose: Self-checking bench for the secure OTP region block
// Assumes: Reference image and status kept in integers
// Notes: Overlay sector 0Ah, array sector 0Bh
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin \
  $display("mismatch %s exp %0h got %0h", n, e, a); failures++; end end
module sora_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [25:0] SECT = 26'h0280000;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic cv, rv, ra, rf, ov, irq;
  logic [2:0] op;
  logic [25:0] ad;
  logic [7:0] wd, rd;
  logic [15:0] q;
  logic [3:0] r;
  int failures = 0;
  int comparisons = 0;
  int mem[1024];
  int stat = 0;
  int mask = 0;
  bit frozen = 0;
  always #4 clock = ~clock;
  sora_host host_u (.clock(clock), .cmd_valid(cv), .cmd_op(op),
    .cmd_addr(ad), .cmd_wdata(wd), .rsp({rv, ra, rf, ov}));
  sora_top dut_u (.clock(clock), .rst_n(rst_n), .cmd_valid(cv),
    .cmd_op(op), .cmd_addr(ad), .cmd_wdata(wd), .rsp_valid_ff(rv),
    .rsp_array_ff(ra), .rsp_fail_ff(rf), .rsp_rdata_ff(rd),
    .overlay_active_ff(ov), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(q), .irq_ff(irq));
  ////////////////////////////////////////////////////////////////////////
  task automatic finish_test;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : finish_test
  task automatic wreg(logic [3:0] a, logic [15:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wreg
  task automatic rreg(logic [3:0] a, logic [15:0] e);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 `CHK("reg", e, q)
  endtask : rreg
  task automatic chk_st;
    rreg(sora_pkg::REG_STAT, stat[15:0]);
    `CHK("irq", (stat & mask) != 0, irq)
  endtask : chk_st
  // Lock byte 10h + region/8, bit region%8; stored value is old AND data
  task automatic prog(int o, logic [7:0] d, logic [25:0] al = 26'h0);
    bit bad;
    bad = !frozen && (mem[16 + o / 256][(o / 32) % 8] == 0 ||
      (o < 16 && (mem[o] & ~d & 8'hFF) != 0));
    host_u.cmd(sora_pkg::OP_PROG, SECT | al | o, d, r);
    if (!frozen && !bad) mem[o] &= d;
    if (bad) stat |= 16;
    stat |= 1;
    `CHK("prog", {2'b10, bad}, r[3:1])
  endtask : prog
  task automatic rdsec(int o);
    host_u.cmd(sora_pkg::OP_READ, SECT | o, 8'h00, r);
    `CHK("read", {3'b100, mem[o][7:0]}, {r[3:1], rd})
  endtask : rdsec
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    #200000;
    failures++;
    finish_test();
  end
  initial
  begin
    for (int i = 0; i < 1024; i++)
      mem[i] = i < 16 ? sora_pkg::RAND_SEED[8*i+:8] : 8'hFF;
    void'($urandom(32'hA314));
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    rreg(sora_pkg::REG_CFG, 16'h0400);
    rreg(sora_pkg::REG_MASK, 16'h0);
    rreg(4'h2, 16'h0);
    chk_st();
    $display("end registers");
    host_u.cmd(sora_pkg::OP_ENTER, SECT, 8'h00, r);
    `CHK("overlay", 1'b1, r[0])
    for (int i = 0; i < 40; i++) rdsec(i);
    rdsec(1023);
    $display("end delivery image");
    mask = 17;
    wreg(sora_pkg::REG_MASK, 16'h0011);
    prog(10'h3E5, 8'h5C, 26'h1C00);
    rdsec(10'h3E5);
    repeat (20) prog(32 + $urandom % 992, 8'($urandom));
    for (int i = 32; i < 1024; i += 37) rdsec(i);
    prog(10'h25, 8'h0F);
    prog(10'h25, 8'hF0);
    rdsec(10'h25);
    prog(10'h14, 8'h5A);
    rdsec(10'h14);
    $display("end programming");
    prog(3, 8'h00);
    prog(3, 8'hFF);
    rdsec(3);
    chk_st();
    wreg(sora_pkg::REG_STAT, 16'h0011);
    stat = 0;
    chk_st();
    $display("end random bytes");
    prog(16, 8'hFD);
    prog(10'h22, 8'h00);
    rdsec(10'h22);
    prog(10'h13, 8'h7F);
    prog(10'h3FE, 8'h00);
    prog(10'h40, 8'h3C);
    host_u.cmd(sora_pkg::OP_ERASE, SECT | 10'h40, 8'h00, r);
    `CHK("erase", 3'b101, r[3:1])
    rdsec(10'h40);
    $display("end locks");
    wreg(sora_pkg::REG_STAT, 16'h0011);
    stat = 0;
    wreg(sora_pkg::REG_CFG, 16'h0);
    frozen = 1;
    rreg(sora_pkg::REG_CFG, 16'h0);
    prog(10'h41, 8'h00);
    rdsec(10'h41);
    chk_st();
    wreg(sora_pkg::REG_CFG, 16'h0400);
    frozen = 0;
    $display("end freeze");
    host_u.cmd(sora_pkg::OP_READ, 26'h02C0005, 8'h00, r);
    `CHK("other", 3'b110, r[3:1])
    host_u.cmd(sora_pkg::OP_READ, SECT | 26'h02005, 8'h00, r);
    `CHK("window", {3'b100, 8'h00}, {r[3:1], rd})
    host_u.cmd(sora_pkg::OP_EXIT, SECT, 8'h00, r);
    `CHK("exit", 1'b0, r[0])
    host_u.cmd(sora_pkg::OP_READ, SECT | 5, 8'h00, r);
    `CHK("array", 3'b110, r[3:1])
    $display("end overlay exit");
    finish_test();
  end
endmodule : sora_top_tb
